// File: logic/overlay_pkg.sv
// Package: overlay map, register layout and timing for the flash/RAM overlay
package overlay_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          DATA_W          = 32;
   // Flash space and RAM windows
   localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
   localparam logic [31:0] FLASH_MASK      = 32'hfff0_0000;
   localparam logic [31:0] RAM_BASE        = 32'h0080_4000;
   localparam logic [31:0] RAM_LAST        = 32'h0080_7fff;
   localparam logic [31:0] SMALL_RAM_BASE  = 32'h0080_6000;
   localparam logic [31:0] SMALL_RAM_STEP  = 32'h0000_1000;
   localparam logic [31:0] LARGE_OFS_MASK  = 32'h0000_1fff;
   localparam logic [31:0] SMALL_OFS_MASK  = 32'h0000_0fff;
   // Bank address fields
   localparam int          LARGE_LSB       = 12;
   localparam int          LARGE_W         = 7;
   localparam int          SMALL_LSB       = 12;
   localparam int          SMALL_W         = 8;
   // Control register map (word offsets, byte addresses)
   localparam logic [7:0]  OFS_CTRL_ONE    = 8'h00;
   localparam logic [7:0]  OFS_LARGE       = 8'h04;
   localparam logic [7:0]  OFS_SMALL_A     = 8'h08;
   localparam logic [7:0]  OFS_SMALL_B     = 8'h0c;
   localparam int          EMU_BIT         = 0;
   localparam int          EN_BIT          = 15;
   localparam logic [15:0] CTRL_RST        = 16'h0000;
   // Settle time after reconfiguration, in CPU clock periods
   localparam int          SETTLE_CLKS     = 3;
   localparam logic [1:0]  SETTLE_CNT      = 2'(SETTLE_CLKS);
   // Route of one access
   typedef enum logic [2:0] {
      ROUTE_FLASH = 3'b001,
      ROUTE_RAM   = 3'b010,
      ROUTE_NONE  = 3'b100
   } route_t;
endpackage

// File: logic/overlay_if.sv
// Interface: CPU internal bus between the core and the overlay logic
`timescale 1ns/1ps
interface overlay_if;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic        rd;
   logic        wr;
   logic [31:0] rdata;
   logic [7:0]  cfg_addr;
   logic [15:0] cfg_wdata;
   logic        cfg_wr;
   logic        cfg_rd;
   logic [15:0] cfg_rdata;
   modport device (input addr, wdata, rd, wr, cfg_addr, cfg_wdata, cfg_wr,
                   cfg_rd, output rdata, cfg_rdata);
   modport cpu (output addr, wdata, rd, wr, cfg_addr, cfg_wdata, cfg_wr,
                cfg_rd, input rdata, cfg_rdata);
endinterface

// File: logic/overlay_remap.sv
// Device end: bank registers and flash-to-RAM address remapping
//
// Contract
// RL1: Large flash bank redirected to 8K RAM
// RL2: Two small banks redirected from 0x806000
// RL3: Overlay RAM reachable at both addresses
// RL4: Large field compares address bits 12..18 (code compares bits 13..18 only)
// RL5: Large redirect only while its enable set
// RL6: Small fields compare address bits 12..19
// RL7: Each small bank enabled separately
// RL8: At most three overlays at once
// RL9: Large bank wins over second small bank
// RL10: CPU waits three clocks after mode set
// RL11: CPU waits three clocks after bank write
// RL12: Leave emulation mode before flash programming
// RL13: Large field value even, start bits
// RL14: Enables act only in emulation mode
// RL15: Ordinary RAM range stays reachable
// RL16: Unmatched flash accesses go to flash
// RL17: Small A at lower block, B above
`timescale 1ns/1ps
module overlay_remap
   import overlay_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   overlay_if.device        bus,
   output logic [31:0]      mem_addr_out,
   output logic             flash_sel_out,
   output logic             ram_sel_out,
   output logic             mem_rd_out,
   output logic             mem_wr_out,
   output logic [31:0]      mem_wdata_out,
   input  wire logic [31:0] mem_rdata_in,
   output logic             emu_mode_out
);
   logic [15:0] ctrl_one_r;
   logic [15:0] ctrl_one_nxt;
   logic [15:0] large_r;
   logic [15:0] large_nxt;
   logic [15:0] small_a_r;
   logic [15:0] small_a_nxt;
   logic [15:0] small_b_r;
   logic [15:0] small_b_nxt;
   logic [15:0] cfg_rdata_r;
   logic [15:0] cfg_rdata_nxt;
   logic        emu;
   logic        in_flash;
   logic        in_ram;
   logic        large_on;
   logic        small_a_on;
   logic        small_b_on;
   logic        large_hit;
   logic        small_a_hit;
   logic        small_b_hit;
   logic        access_ok;
   logic [5:0]  large_tag;
   logic [7:0]  small_tag;
   logic [31:0] large_ofs;
   logic [31:0] small_ofs;
   logic [31:0] mapped;
   route_t      route;

   // Which window serves the access, highest priority first
   typedef enum logic [5:0] {
      SRC_LARGE   = 6'b000001,
      SRC_SMALL_B = 6'b000010,
      SRC_SMALL_A = 6'b000100,
      SRC_FLASH   = 6'b001000,
      SRC_RAM     = 6'b010000,
      SRC_NONE    = 6'b100000
   } src_t;
   src_t        src;

   // Bank registers; unused bits are masked so they read back as zero
   always_comb begin
      ctrl_one_nxt = ctrl_one_r;
      large_nxt    = large_r;
      small_a_nxt  = small_a_r;
      small_b_nxt  = small_b_r;
      if (bus.cfg_wr) begin
         case (bus.cfg_addr)
            OFS_CTRL_ONE: ctrl_one_nxt = bus.cfg_wdata & 16'h0001;
            OFS_LARGE:    large_nxt    = bus.cfg_wdata & 16'h807f;
            OFS_SMALL_A:  small_a_nxt  = bus.cfg_wdata & 16'h80ff;
            OFS_SMALL_B:  small_b_nxt  = bus.cfg_wdata & 16'h80ff;
            default:      ;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ctrl_one_r <= CTRL_RST;
         large_r    <= CTRL_RST;
         small_a_r  <= CTRL_RST;
         small_b_r  <= CTRL_RST;
      end else begin
         ctrl_one_r <= ctrl_one_nxt;
         large_r    <= large_nxt;
         small_a_r  <= small_a_nxt;
         small_b_r  <= small_b_nxt;
      end
   end

   // Read data stand one cycle, then drop to zero
   always_comb begin
      cfg_rdata_nxt = 16'h0000;
      if (bus.cfg_rd) begin
         case (bus.cfg_addr)
            OFS_CTRL_ONE: cfg_rdata_nxt = ctrl_one_r;
            OFS_LARGE:    cfg_rdata_nxt = large_r;
            OFS_SMALL_A:  cfg_rdata_nxt = small_a_r;
            OFS_SMALL_B:  cfg_rdata_nxt = small_b_r;
            default:      cfg_rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in)
         cfg_rdata_r <= CTRL_RST;
      else
         cfg_rdata_r <= cfg_rdata_nxt;
   end

   assign bus.cfg_rdata = cfg_rdata_r;
   assign emu           = ctrl_one_r[EMU_BIT]; // RL14
   assign emu_mode_out  = emu;

   // Enables count only in emulation mode
   assign in_flash   = (bus.addr & FLASH_MASK) == FLASH_BASE;
   assign in_ram     = bus.addr >= RAM_BASE && bus.addr <= RAM_LAST;
   assign large_on   = emu && large_r[EN_BIT]; // RL5 RL14
   assign small_a_on = emu && small_a_r[EN_BIT]; // RL7 RL14
   assign small_b_on = emu && small_b_r[EN_BIT]; // RL7 RL14

   // Bit 12 lies inside an 8K bank, so the field's low bit is not compared
   assign large_tag   = bus.addr[LARGE_LSB+1 +: LARGE_W-1];
   assign small_tag   = bus.addr[SMALL_LSB +: SMALL_W];
   assign large_hit   = in_flash && large_on
      && large_tag == large_r[LARGE_W-1:1]; // RL4
   assign small_a_hit = in_flash && small_a_on
      && small_tag == small_a_r[SMALL_W-1:0]; // RL6
   assign small_b_hit = in_flash && small_b_on
      && small_tag == small_b_r[SMALL_W-1:0]; // RL6
   assign large_ofs   = bus.addr & LARGE_OFS_MASK;
   assign small_ofs   = bus.addr & SMALL_OFS_MASK;

   // Fixed priority: large, then small B, then small A; three overlays max
   always_comb begin
      if (large_hit)
         src = SRC_LARGE; // RL9 RL8
      else if (small_b_hit)
         src = SRC_SMALL_B; // RL9
      else if (small_a_hit)
         src = SRC_SMALL_A;
      else if (in_flash)
         src = SRC_FLASH; // RL16
      else if (in_ram)
         src = SRC_RAM; // RL15
      else
         src = SRC_NONE;
   end

   // Window base plus the offset inside the bank
   always_comb begin
      mapped = bus.addr;
      route  = ROUTE_NONE;
      case (src)
         SRC_LARGE: begin
            mapped = RAM_BASE | large_ofs; // RL1
            route  = ROUTE_RAM;
         end
         SRC_SMALL_B: begin
            mapped = (SMALL_RAM_BASE + SMALL_RAM_STEP) // RL17
                     | small_ofs; // RL2
            route  = ROUTE_RAM;
         end
         SRC_SMALL_A: begin
            mapped = SMALL_RAM_BASE | small_ofs; // RL2 RL17
            route  = ROUTE_RAM;
         end
         SRC_FLASH: begin
            route  = ROUTE_FLASH; // RL16
         end
         SRC_RAM: begin
            route  = ROUTE_RAM; // RL15 RL3
         end
         SRC_NONE: begin
            route  = ROUTE_NONE;
         end
         default: begin
            route  = ROUTE_NONE;
         end
      endcase
   end

   // Pass-through to memories, same cycle; writes allowed both ways
   assign mem_addr_out  = mapped;
   assign flash_sel_out = route == ROUTE_FLASH;
   assign ram_sel_out   = route == ROUTE_RAM; // RL3
   // Accesses outside flash and RAM reach neither memory
   assign access_ok     = route != ROUTE_NONE;
   assign mem_rd_out    = bus.rd && access_ok;
   assign mem_wr_out    = bus.wr && access_ok;
   assign mem_wdata_out = bus.wdata;
   assign bus.rdata     = mem_rdata_in;
endmodule

// File: logic/overlay_cpu.sv
// CPU end: drives the bus, holds off flash reads while a change settles
`timescale 1ns/1ps
module overlay_cpu
   import overlay_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   overlay_if.cpu           bus,
   input  wire logic [31:0] req_addr_in,
   input  wire logic [31:0] req_wdata_in,
   input  wire logic        req_rd_in,
   input  wire logic        req_wr_in,
   input  wire logic [7:0]  cfg_addr_in,
   input  wire logic [15:0] cfg_wdata_in,
   input  wire logic        cfg_wr_in,
   input  wire logic        cfg_rd_in,
   output logic             req_ready_out,
   output logic [31:0]      rdata_out,
   output logic [15:0]      cfg_rdata_out
);
   logic [1:0] settle_r, settle_nxt;
   logic       in_flash;

   assign in_flash = (req_addr_in & FLASH_MASK) == FLASH_BASE;

   // Config writes restart the wait; flash reads stall until it ends
   always_comb begin
      settle_nxt = settle_r;
      if (cfg_wr_in)
         settle_nxt = SETTLE_CNT; // RL10 RL11
      else if (settle_r != 2'h0)
         settle_nxt = settle_r - 2'h1;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in)
         settle_r <= 2'h0;
      else
         settle_r <= settle_nxt;
   end

   assign req_ready_out = !(req_rd_in && in_flash && settle_r != 2'h0);
   assign bus.addr      = req_addr_in;
   assign bus.wdata     = req_wdata_in;
   assign bus.rd        = req_rd_in && req_ready_out; // RL10 RL11
   assign bus.wr        = req_wr_in;
   assign bus.cfg_addr  = cfg_addr_in;
   assign bus.cfg_wdata = cfg_wdata_in;
   assign bus.cfg_wr    = cfg_wr_in;
   assign bus.cfg_rd    = cfg_rd_in;
   assign rdata_out     = bus.rdata;
   assign cfg_rdata_out = bus.cfg_rdata;
endmodule

// File: verif/overlay_props.sv
// Checker: remap, settle and readback relations on the CPU bus
`timescale 1ns/1ps
module overlay_props
   import overlay_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic [31:0] addr,
   input wire logic        rd,
   input wire logic        wr,
   input wire logic [7:0]  cfg_addr,
   input wire logic [15:0] cfg_wdata,
   input wire logic        cfg_wr,
   input wire logic        cfg_rd,
   input wire logic [15:0] cfg_rdata,
   input wire logic [31:0] mem_addr_out,
   input wire logic        ram_sel_out,
   input wire logic        emu_mode_out
);
   logic [15:0] b_r [4];
   logic        fa, ac, hl, hb, ha, hit, rm;
   logic [31:0] xl, xa, xb;
   // Mirror of the registers, taken on the same edge as the device
   always_ff @(posedge clock_in)
      if (rst_in) b_r <= '{default: 16'h0000};
      else if (cfg_wr & cfg_addr[7:4] == 4'h0 & cfg_addr[1:0] == 2'h0)
         b_r[cfg_addr[3:2]] <= cfg_wdata;
   assign fa = (rd | wr) & (addr & FLASH_MASK) == FLASH_BASE;
   assign ac = fa & emu_mode_out;
   assign hl = ac & b_r[1][EN_BIT] & addr[18:13] == b_r[1][6:1];
   assign hb = ac & b_r[3][EN_BIT] & addr[19:12] == b_r[3][7:0] & ~hl;
   assign ha = ac & b_r[2][EN_BIT] & addr[19:12] == b_r[2][7:0] & ~hl & ~hb;
   assign hit = hl | hb | ha;
   assign rm = (rd | wr) & addr >= RAM_BASE & addr <= RAM_LAST;
   assign xl = RAM_BASE | addr & LARGE_OFS_MASK;
   assign xa = SMALL_RAM_BASE | addr & SMALL_OFS_MASK;
   assign xb = xa + SMALL_RAM_STEP;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   a_large_map:
      assert property (hl |-> ram_sel_out && mem_addr_out == xl)
      else $error("large bank remap wrong");
   a_small_b_map:
      assert property (hb |-> ram_sel_out && mem_addr_out == xb)
      else $error("small bank b remap wrong");
   a_small_a_map:
      assert property (ha |-> ram_sel_out && mem_addr_out == xa)
      else $error("small bank a remap wrong");
   a_flash_pass:
      assert property (fa & ~hit |-> !ram_sel_out && mem_addr_out == addr)
      else $error("flash access altered");
   a_ram_direct:
      assert property (rm |-> ram_sel_out && mem_addr_out == addr)
      else $error("ram access altered");
   a_settle_hold:
      assert property (cfg_wr |=> (!(rd && fa))[*3])
      else $error("flash read inside settle time");
   a_emu_follow:
      assert property (cfg_wr && cfg_addr == OFS_CTRL_ONE
         |=> emu_mode_out == b_r[0][EMU_BIT]) else $error("mode bit lost");
   a_cfg_idle_zero:
      assert property (!cfg_rd || cfg_addr > OFS_SMALL_B
         |=> cfg_rdata == 16'h0000) else $error("stray register data");
   c_large: cover property (hl);
   c_small_b: cover property (hb);
   c_small_a: cover property (ha);
endmodule

// File: verif/tb.sv
// Testbench: both overlay ends joined, user sides driven and checked
`timescale 1ns/1ps
module tb;
   import overlay_pkg::*;
   logic        clock_in = 1'b0, rst_in = 1'b1, rd = 1'b0, wr = 1'b0;
   logic        c_wr = 1'b0, c_rd = 1'b0, c_pend = 1'b0;
   logic        ready, fsel, rsel, m_rd, m_wr, emu;
   logic [31:0] a = 32'h0, wd = 32'h0, m_rdata = 32'h0, rdata, m_addr, r;
   logic [7:0]  c_a = 8'h00, fa, fb;
   logic [15:0] c_d = 16'h0000, c_q;
   logic [11:0] ofs;
   logic [31:0] m_wd;
   logic [33:0] mq [$];
   logic [15:0] cq [$];
   int          failures = 0, total_checks = 0, cyc = 0, n;
   overlay_if bus ();
   overlay_cpu u_overlay_cpu (.clock_in, .rst_in, .bus, .req_addr_in(a),
      .req_wdata_in(wd), .req_rd_in(rd), .req_wr_in(wr), .cfg_addr_in(c_a),
      .cfg_wdata_in(c_d), .cfg_wr_in(c_wr), .cfg_rd_in(c_rd),
      .req_ready_out(ready), .rdata_out(rdata), .cfg_rdata_out(c_q));
   overlay_remap u_overlay_remap (.clock_in, .rst_in, .bus,
      .mem_addr_out(m_addr), .flash_sel_out(fsel), .ram_sel_out(rsel),
      .mem_rd_out(m_rd), .mem_wr_out(m_wr), .mem_wdata_out(m_wd),
      .mem_rdata_in(m_rdata), .emu_mode_out(emu));
   overlay_props u_overlay_props (.clock_in, .rst_in, .addr(bus.addr),
      .rd(bus.rd), .wr(bus.wr), .cfg_addr(bus.cfg_addr),
      .cfg_wdata(bus.cfg_wdata), .cfg_wr(bus.cfg_wr), .cfg_rd(bus.cfg_rd),
      .cfg_rdata(bus.cfg_rdata), .mem_addr_out(m_addr),
      .ram_sel_out(rsel), .emu_mode_out(emu));
   task automatic cmp_mem(input logic [33:0] g, input logic [33:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_cfg(input logic [15:0] g, input logic [15:0] e);
      cmp_mem({18'h0, g}, {18'h0, e});
   endtask
   task automatic finish_test();
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Idle edge after each strobe keeps one assignment per time step
   task automatic cfg(input logic [7:0] ad, input logic w,
                      input logic [15:0] d);
      c_a <= ad;
      c_d <= d;
      c_wr <= w;
      c_rd <= !w;
      if (!w) cq.push_back(d);
      @(posedge clock_in);
      c_wr <= 1'b0;
      c_rd <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic mem(input logic [31:0] ad, input logic w,
                      input logic [33:0] e);
      a <= ad;
      wd <= r;
      rd <= !w;
      wr <= w;
      mq.push_back(e);
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (ready !== 1'b1 && n < 20);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clock_in);
   endtask
   initial forever #20 clock_in = ~clock_in;
   always @(negedge clock_in) begin
      if (c_pend) cmp_cfg(c_q, cq.pop_front());
      c_pend = bus.cfg_rd;
      if (m_rd | m_wr) cmp_mem({fsel, rsel, m_addr}, mq.pop_front());
      if (m_rd) cmp_mem({2'b00, rdata}, {2'b00, m_rdata});
      if (m_wr) cmp_mem({2'b00, m_wd}, {2'b00, r});
      if (++cyc == 2000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      r = $urandom(27);
      fa = {2'b01, r[5:0]};
      fb = {2'b01, ~r[5:0]};
      ofs = r[17:6];
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      m_rdata <= $urandom;
      @(posedge clock_in);
      for (int i = 0; i < 5; i++)
         cfg(8'(4 * i), 1'b0, 16'h0000);
      mem(32'h0000_2010, 1'b0, {2'b10, 32'h0000_2010});
      cfg(OFS_LARGE, 1'b1, 16'h8002);
      mem(32'h0000_2010, 1'b0, {2'b10, 32'h0000_2010});
      // One stall fewer: the idle edge after the write counts too
      cmp_mem(34'(n - 1), 34'(SETTLE_CLKS - 1));
      cfg(OFS_CTRL_ONE, 1'b1, 16'h0001);
      cfg(OFS_LARGE, 1'b0, 16'h8002);
      mem(32'h0000_2010, 1'b0, {2'b01, 32'h0080_4010});
      cfg(OFS_SMALL_A, 1'b1, {8'h80, fa});
      cfg(OFS_SMALL_B, 1'b1, {8'h80, fb});
      cfg(OFS_SMALL_A, 1'b0, {8'h80, fa});
      mem({12'h0, fa, ofs}, 1'b1, {2'b01, SMALL_RAM_BASE | ofs});
      mem({12'h0, fb, ofs}, 1'b0,
         {2'b01, SMALL_RAM_BASE + SMALL_RAM_STEP | ofs});
      mem(32'h0000_3abc, 1'b0, {2'b01, 32'h0080_5abc});
      cfg(OFS_SMALL_B, 1'b1, 16'h8002);
      mem(32'h0000_2abc, 1'b0, {2'b01, 32'h0080_4abc});
      cfg(OFS_LARGE, 1'b1, 16'h0002);
      mem(32'h0000_2abc, 1'b0, {2'b01, 32'h0080_7abc});
      mem(32'h0080_4abc, 1'b1, {2'b01, 32'h0080_4abc});
      cfg(OFS_CTRL_ONE, 1'b1, 16'h0000);
      mem(32'h0000_2abc, 1'b0, {2'b10, 32'h0000_2abc});
      finish_test();
   end
endmodule
